// ---- logic/cpu_flow_consts.svh ----
// Purpose: Constants shared by the flow and system control core.
// Assumes: Included by its bare name; definitions only.
// Notes: Opcode values are the encoding of this core's own instruction word.
`ifndef CPU_FLOW_CONSTS_SVH
`define CPU_FLOW_CONSTS_SVH

// ----------------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------------
`define INSTR_W 16
`define OP_MSB 15
`define OP_LSB 12
`define IMM_MSB 7

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define OP_NOP 4'h0
`define OP_DEC_SKIP_ACC 4'h1
`define OP_INC_SKIP_MEM 4'h2
`define OP_DEC_SKIP_MEM 4'h3
`define OP_CALL 4'h4
`define OP_JUMP 4'h5
`define OP_RET_VALUE 4'h6
`define OP_RET 4'h7
`define OP_RET_INT 4'h8
`define OP_PC_ADD 4'h9
`define OP_INT_ON 4'ha
`define OP_INT_OFF 4'hb
`define OP_HALT_SYS 4'hc
`define OP_HALT_CORE 4'hd
`define OP_SOFT_RESET 4'he
`define OP_WDT_CLEAR 4'hf

// ----------------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------------
`define ACC_RST 8'h00
`define GIE_RST 1'b0
`define STACK_STEP 2

`endif

// ---- logic/cpu_flow_core.sv ----
// Purpose: Executes the skip, call, return, jump and system control instructions.
// Assumes: Program, data and stack memories answer combinationally to the registered addresses.
// Notes: One instruction cycle is two clocks: fetch phase, then execute phase.
// Functional notes
// - Decrement accumulator, skip when zero, set flags.
// - Increment memory byte, write back, skip zero.
// - Decrement memory byte, write back, skip zero.
// - Call pushes next address, jumps, stack plus two.
// - Jump reaches any program address, flags kept.
// - Return with value loads accumulator, then returns.
// - Return drops stack by two, pops counter.
// - Interrupt return also sets global enable.
// - Computed jump adds unsigned accumulator to counter.
// - Interrupt-on instruction sets global enable.
// - Interrupt-off instruction clears global enable.
// - Full halt stops system clocks and oscillators.
// - Core halt gates core clock, oscillators run.
// - Software reset equals a hardware reset.
// - Watchdog restart clears the watchdog count.
// - Control transfers take two instruction cycles.
// - Skips take two cycles taken, one otherwise.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_flow_consts.svh"

module cpu_flow_core
    import cpu_flow_pkg::*;
#(
    parameter int PC_W = 12,
    parameter int SP_W = 8,
    parameter int DA_W = 8
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    output logic [PC_W-1:0] pmem_addr_o,
    input wire logic [`INSTR_W-1:0] instr_i,
    output logic [DA_W-1:0] dmem_addr_o,
    input wire logic [7:0] dmem_rdata_i,
    output logic [7:0] dmem_wdata_o,
    output logic dmem_we_o,
    output logic [SP_W-1:0] stack_addr_o,
    input wire logic [15:0] stack_rdata_i,
    output logic [15:0] stack_wdata_o,
    output logic stack_we_o,
    input wire logic wake_i,
    output logic [7:0] acc_o,
    output logic zero_flag_o,
    output logic carry_flag_o,
    output logic auxiliary_carry_flag_o,
    output logic overflow_flag_o,
    output logic int_enable_o,
    output logic sys_clock_stop_o,
    output logic core_clock_stop_o,
    output logic soft_reset_o,
    output logic wdt_clear_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    core_state_t state, next_state;
    logic phase, next_phase;
    logic bubble, next_bubble;
    logic [`INSTR_W-1:0] instr, next_instr;
    logic [PC_W-1:0] pc, next_pc;
    logic [SP_W-1:0] sp, next_sp;
    logic [7:0] acc, next_acc;
    logic zf, cf, acf, ovf, next_zf, next_cf, next_acf, next_ovf;
    logic gie, next_gie;
    logic [DA_W-1:0] dmem_addr, next_dmem_addr;
    logic [7:0] dmem_wdata, next_dmem_wdata;
    logic dmem_we, next_dmem_we;
    logic [SP_W-1:0] stack_addr, next_stack_addr;
    logic [15:0] stack_wdata, next_stack_wdata;
    logic stack_we, next_stack_we;
    logic sys_stop, next_sys_stop, core_stop, next_core_stop;
    logic soft_reset, next_soft_reset, wdt_clear, next_wdt_clear;

    op_t op, fetch_op;
    logic exec;
    logic [7:0] step_result;
    logic step_zero, step_carry, step_aux, step_ovf;

    assign op = op_t'(instr[`OP_MSB:`OP_LSB]);
    assign fetch_op = op_t'(instr_i[`OP_MSB:`OP_LSB]);
    assign exec = (state == st_run) && phase && !bubble;

    step_unit u_step (
        .value_i(op == op_dec_skip_acc ? acc : dmem_rdata_i),
        .dec_i(op != op_inc_skip_mem),
        .result_o(step_result),
        .zero_o(step_zero),
        .carry_o(step_carry),
        .aux_carry_o(step_aux),
        .overflow_o(step_ovf)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_bubble = bubble;
        next_instr = instr;
        next_pc = pc;
        next_sp = sp;
        next_acc = acc;
        next_zf = zf;
        next_cf = cf;
        next_acf = acf;
        next_ovf = ovf;
        next_gie = gie;
        next_dmem_addr = dmem_addr;
        next_dmem_wdata = dmem_wdata;
        next_dmem_we = 1'b0;
        next_stack_addr = stack_addr;
        next_stack_wdata = stack_wdata;
        next_stack_we = 1'b0;
        next_sys_stop = sys_stop;
        next_core_stop = core_stop;
        next_soft_reset = 1'b0;
        next_wdt_clear = 1'b0;
        case (state)
            st_run: begin
                next_phase = !phase;
                if (!phase) begin
                    // A bubble fetch is thrown away so its addresses never drive memory.
                    if (!bubble) begin
                        next_instr = instr_i;
                        next_dmem_addr = instr_i[DA_W-1:0];
                        if (fetch_op == op_ret || fetch_op == op_ret_value || fetch_op == op_ret_int) begin
                            next_stack_addr = sp - SP_W'(`STACK_STEP);
                        end else begin
                            next_stack_addr = sp;
                        end
                    end
                end else if (bubble) begin
                    next_bubble = 1'b0;
                end else begin
                    next_pc = pc + PC_W'(1);
                    case (op)
                        op_dec_skip_acc, op_inc_skip_mem, op_dec_skip_mem: begin
                            if (op == op_dec_skip_acc) begin
                                next_acc = step_result;
                            end else begin
                                next_dmem_wdata = step_result;
                                next_dmem_we = 1'b1;
                            end
                            next_zf = step_zero;
                            next_cf = step_carry;
                            next_acf = step_aux;
                            next_ovf = step_ovf;
                            if (step_zero) begin
                                next_pc = pc + PC_W'(2);
                                next_bubble = 1'b1;
                            end
                        end
                        op_call: begin
                            next_stack_wdata = 16'(pc + PC_W'(1));
                            next_stack_we = 1'b1;
                            next_sp = sp + SP_W'(`STACK_STEP);
                            next_pc = instr[PC_W-1:0];
                            next_bubble = 1'b1;
                        end
                        op_jump: begin
                            next_pc = instr[PC_W-1:0];
                            next_bubble = 1'b1;
                        end
                        op_ret_value, op_ret, op_ret_int: begin
                            if (op == op_ret_value) begin
                                next_acc = instr[`IMM_MSB:0];
                            end
                            if (op == op_ret_int) begin
                                next_gie = 1'b1;
                            end
                            next_sp = sp - SP_W'(`STACK_STEP);
                            next_pc = stack_rdata_i[PC_W-1:0];
                            next_bubble = 1'b1;
                        end
                        op_pc_add: begin
                            next_pc = pc + PC_W'(acc);
                            next_bubble = 1'b1;
                        end
                        op_int_on: next_gie = 1'b1;
                        op_int_off: next_gie = 1'b0;
                        op_halt_sys: begin
                            next_state = st_halt_sys;
                            next_sys_stop = 1'b1;
                        end
                        op_halt_core: begin
                            next_state = st_halt_core;
                            next_core_stop = 1'b1;
                        end
                        op_wdt_clear: next_wdt_clear = 1'b1;
                        default: begin
                        end
                    endcase
                end
            end
            st_halt_sys, st_halt_core: begin
                if (wake_i) begin
                    next_state = st_run;
                    next_sys_stop = 1'b0;
                    next_core_stop = 1'b0;
                end
            end
            default: next_state = st_run;
        endcase
        // Software reset restores every register except the soft_reset strobe, which it sets, to its power-up value.
        if (exec && op == op_soft_reset) begin
            next_state = st_run;
            next_phase = 1'b0;
            next_bubble = 1'b0;
            next_instr = '0;
            next_pc = '0;
            next_sp = '0;
            next_acc = `ACC_RST;
            next_zf = 1'b0;
            next_cf = 1'b0;
            next_acf = 1'b0;
            next_ovf = 1'b0;
            next_gie = `GIE_RST;
            next_dmem_addr = '0;
            next_dmem_wdata = 8'h00;
            next_stack_addr = '0;
            next_stack_wdata = 16'h0000;
            next_soft_reset = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= st_run;
            phase <= 1'b0;
            bubble <= 1'b0;
            instr <= '0;
            pc <= '0;
            sp <= '0;
            acc <= `ACC_RST;
            zf <= 1'b0;
            cf <= 1'b0;
            acf <= 1'b0;
            ovf <= 1'b0;
            gie <= `GIE_RST;
            dmem_addr <= '0;
            dmem_wdata <= 8'h00;
            dmem_we <= 1'b0;
            stack_addr <= '0;
            stack_wdata <= 16'h0000;
            stack_we <= 1'b0;
            sys_stop <= 1'b0;
            core_stop <= 1'b0;
            soft_reset <= 1'b0;
            wdt_clear <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            bubble <= next_bubble;
            instr <= next_instr;
            pc <= next_pc;
            sp <= next_sp;
            acc <= next_acc;
            zf <= next_zf;
            cf <= next_cf;
            acf <= next_acf;
            ovf <= next_ovf;
            gie <= next_gie;
            dmem_addr <= next_dmem_addr;
            dmem_wdata <= next_dmem_wdata;
            dmem_we <= next_dmem_we;
            stack_addr <= next_stack_addr;
            stack_wdata <= next_stack_wdata;
            stack_we <= next_stack_we;
            sys_stop <= next_sys_stop;
            core_stop <= next_core_stop;
            soft_reset <= next_soft_reset;
            wdt_clear <= next_wdt_clear;
        end
    end

    assign pmem_addr_o = pc;
    assign dmem_addr_o = dmem_addr;
    assign dmem_wdata_o = dmem_wdata;
    assign dmem_we_o = dmem_we;
    assign stack_addr_o = stack_addr;
    assign stack_wdata_o = stack_wdata;
    assign stack_we_o = stack_we;
    assign acc_o = acc;
    assign zero_flag_o = zf;
    assign carry_flag_o = cf;
    assign auxiliary_carry_flag_o = acf;
    assign overflow_flag_o = ovf;
    assign int_enable_o = gie;
    assign sys_clock_stop_o = sys_stop;
    assign core_clock_stop_o = core_stop;
    assign soft_reset_o = soft_reset;
    assign wdt_clear_o = wdt_clear;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    acc_skip_a: assert property (exec && op == op_dec_skip_acc && acc == 8'h01 |=> acc == 8'h00 && zf && bubble && pc == $past(pc) + PC_W'(2)) else $error("accumulator skip wrong");
    mem_inc_a: assert property (exec && op == op_inc_skip_mem |=> dmem_we && dmem_wdata == $past(dmem_rdata_i) + 8'h01) else $error("memory increment wrong");
    mem_dec_a: assert property (exec && op == op_dec_skip_mem |=> dmem_we && dmem_wdata == $past(dmem_rdata_i) - 8'h01 && bubble == (dmem_wdata == 8'h00)) else $error("memory decrement wrong");
    call_push_a: assert property (exec && op == op_call |=> stack_we && stack_wdata == 16'($past(pc) + PC_W'(1)) && sp == $past(sp) + SP_W'(2) && stack_addr == $past(sp)) else $error("call push wrong");
    jump_target_a: assert property (exec && op == op_jump |=> pc == $past(instr[PC_W-1:0]) && $stable({zf, cf, acf, ovf})) else $error("jump target wrong");
    ret_value_a: assert property (exec && op == op_ret_value |=> acc == $past(instr[7:0]) && $stable({zf, cf, acf, ovf})) else $error("return value wrong");
    ret_pop_a: assert property (exec && (op == op_ret || op == op_ret_value) |=> sp == $past(sp) - SP_W'(2) && pc == $past(stack_rdata_i[PC_W-1:0])) else $error("return pop wrong");
    reti_enable_a: assert property (exec && op == op_ret_int |=> gie) else $error("interrupt return left enable off");
    pc_add_a: assert property (exec && op == op_pc_add |=> pc == $past(pc) + PC_W'($past(acc))) else $error("computed jump wrong");
    int_on_a: assert property (exec && op == op_int_on |=> gie) else $error("enable not set");
    int_off_a: assert property (exec && op == op_int_off |=> !gie) else $error("enable not cleared");
    halt_sys_a: assert property (exec && op == op_halt_sys ##1 !wake_i |=> sys_stop && $stable(pc)) else $error("full halt lost");
    halt_core_a: assert property (exec && op == op_halt_core |=> core_stop && !sys_stop) else $error("core halt wrong");
    soft_reset_a: assert property (exec && op == op_soft_reset |=> soft_reset && pc == '0 && sp == '0 && !gie ##1 !soft_reset) else $error("soft reset wrong");
    wdt_clear_a: assert property (exec && op == op_wdt_clear |=> wdt_clear ##1 !wdt_clear) else $error("watchdog clear wrong");
    two_cycle_a: assert property (exec && (op == op_jump || op == op_call || op == op_pc_add) |=> bubble [*2] ##1 !bubble) else $error("transfer not two cycles");
    no_skip_a: assert property (exec && op == op_dec_skip_acc && acc != 8'h01 |=> !bubble && pc == $past(pc) + PC_W'(1)) else $error("skip taken wrongly");
    discard_a: assert property (bubble && phase |=> !dmem_we && !stack_we && $stable(acc) && $stable(gie)) else $error("skipped instruction acted");

    call_seen_c: cover property (exec && op == op_call ##4 exec && op == op_ret);
    skip_seen_c: cover property (exec && op == op_inc_skip_mem ##1 bubble);
    reti_seen_c: cover property (exec && op == op_ret_int);
    halt_wake_c: cover property (core_stop ##1 wake_i ##1 !core_stop);

endmodule : cpu_flow_core

`default_nettype wire

// ---- logic/cpu_flow_pkg.sv ----
// Purpose: Types of the flow and system control core.
// Assumes: cpu_flow_consts.svh holds the encodings.
// Notes: None.
`default_nettype none
`include "cpu_flow_consts.svh"

package cpu_flow_pkg;

    typedef enum logic [3:0] {
        op_nop = `OP_NOP,
        op_dec_skip_acc = `OP_DEC_SKIP_ACC,
        op_inc_skip_mem = `OP_INC_SKIP_MEM,
        op_dec_skip_mem = `OP_DEC_SKIP_MEM,
        op_call = `OP_CALL,
        op_jump = `OP_JUMP,
        op_ret_value = `OP_RET_VALUE,
        op_ret = `OP_RET,
        op_ret_int = `OP_RET_INT,
        op_pc_add = `OP_PC_ADD,
        op_int_on = `OP_INT_ON,
        op_int_off = `OP_INT_OFF,
        op_halt_sys = `OP_HALT_SYS,
        op_halt_core = `OP_HALT_CORE,
        op_soft_reset = `OP_SOFT_RESET,
        op_wdt_clear = `OP_WDT_CLEAR
    } op_t;

    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_halt_sys = 2'b01,
        st_halt_core = 2'b10
    } core_state_t;

endpackage : cpu_flow_pkg

`default_nettype wire

// ---- logic/step_unit.sv ----
// Purpose: Add or subtract one on a byte and derive the four arithmetic flags.
// Assumes: Purely combinational; the caller registers the results.
// Notes: Carry is the borrow when decrementing.
`timescale 1ns/10ps
`default_nettype none

module step_unit (
    input wire logic [7:0] value_i,
    input wire logic dec_i,
    output logic [7:0] result_o,
    output logic zero_o,
    output logic carry_o,
    output logic aux_carry_o,
    output logic overflow_o
);
    always_comb begin
        if (dec_i) begin
            result_o = value_i - 8'h01;
            carry_o = (value_i == 8'h00);
            aux_carry_o = (value_i[3:0] == 4'h0);
            overflow_o = (value_i == 8'h80);
        end else begin
            result_o = value_i + 8'h01;
            carry_o = (value_i == 8'hff);
            aux_carry_o = (value_i[3:0] == 4'hf);
            overflow_o = (value_i == 8'h7f);
        end
        zero_o = (result_o == 8'h00);
    end
endmodule : step_unit

`default_nettype wire

// ---- tb/cpu_flow_and_system_control_tb.sv ----
// Purpose: Self-checking bench of the flow and system control core.
// Assumes: Opcode encodings from cpu_flow_consts.svh.
// Notes: Timing is judged from intervals between program counter changes.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_flow_consts.svh"

module cpu_flow_and_system_control_tb;
    import cpu_flow_pkg::*;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wake_i = 1'b0;
    logic [11:0] pmem_addr_o;
    logic [15:0] instr_i;
    logic [7:0] dmem_addr_o, dmem_rdata_i, dmem_wdata_o, acc_o;
    logic [7:0] stack_addr_o;
    logic [15:0] stack_rdata_i, stack_wdata_o;
    logic dmem_we_o, stack_we_o, zero_flag_o, carry_flag_o, auxiliary_carry_flag_o, overflow_flag_o;
    logic int_enable_o, sys_clock_stop_o, core_clock_stop_o, soft_reset_o, wdt_clear_o;
    int fail_count = 0;
    int compares = 0;
    int wdt_n, gie_n;

    always #2 clock_i = ~clock_i;

    cpu_flow_core dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .pmem_addr_o(pmem_addr_o), .instr_i(instr_i),
        .dmem_addr_o(dmem_addr_o), .dmem_rdata_i(dmem_rdata_i), .dmem_wdata_o(dmem_wdata_o),
        .dmem_we_o(dmem_we_o), .stack_addr_o(stack_addr_o), .stack_rdata_i(stack_rdata_i),
        .stack_wdata_o(stack_wdata_o), .stack_we_o(stack_we_o), .wake_i(wake_i), .acc_o(acc_o),
        .zero_flag_o(zero_flag_o), .carry_flag_o(carry_flag_o), .auxiliary_carry_flag_o(auxiliary_carry_flag_o),
        .overflow_flag_o(overflow_flag_o), .int_enable_o(int_enable_o), .sys_clock_stop_o(sys_clock_stop_o),
        .core_clock_stop_o(core_clock_stop_o), .soft_reset_o(soft_reset_o), .wdt_clear_o(wdt_clear_o));

    mem_model mem (.clock_i(clock_i), .pmem_addr_i(pmem_addr_o), .instr_o(instr_i), .dmem_addr_i(dmem_addr_o),
        .dmem_rdata_o(dmem_rdata_i), .dmem_wdata_i(dmem_wdata_o), .dmem_we_i(dmem_we_o),
        .stack_addr_i(stack_addr_o), .stack_rdata_o(stack_rdata_i), .stack_wdata_i(stack_wdata_o),
        .stack_we_i(stack_we_o));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Pulse counts are taken after each edge has settled.
    always @(posedge clock_i) begin
        #1;
        if (reset_n_i) begin
            wdt_n += int'(wdt_clear_o);
            gie_n += int'(int_enable_o);
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] op(input logic [3:0] o, input logic [11:0] v);
        return {o, v};
    endfunction : op

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step

    // Program and stack memories are cleared while reset is held, then the program is loaded.
    task automatic restart(input logic [15:0] words[$]);
        reset_n_i = 1'b0;
        for (int i = 0; i < 4096; i++) mem.prog[i] = 16'h0000;
        for (int i = 0; i < 256; i++) mem.stack[i] = 16'h0000;
        for (int i = 0; i < words.size(); i += 2) mem.prog[words[i][11:0]] = words[i + 1];
        wdt_n = 0;
        gie_n = 0;
        step(3);
        reset_n_i = 1'b1;
    endtask : restart

    task automatic wait_pc(input logic [11:0] a, output time t);
        for (int i = 0; i < 60 && pmem_addr_o !== a; i++) step(1);
        t = $time;
        check(16'(pmem_addr_o), 16'(a));
    endtask : wait_pc

    task automatic flags(input logic [3:0] exp);
        check(16'({zero_flag_o, carry_flag_o, auxiliary_carry_flag_o, overflow_flag_o}), 16'(exp));
    endtask : flags

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic skips();
        time t0, t1, t2, t3;
        restart('{16'h0, op(`OP_DEC_SKIP_MEM, 12'h005), 16'h1, op(`OP_INC_SKIP_MEM, 12'h006),
            16'h2, op(`OP_INC_SKIP_MEM, 12'h007), 16'h3, op(`OP_INC_SKIP_MEM, 12'h008),
            16'h4, op(`OP_DEC_SKIP_MEM, 12'h009), 16'h5, op(`OP_DEC_SKIP_ACC, 12'h000),
            16'h6, op(`OP_JUMP, 12'h006)});
        mem.data[5] = 8'h01;
        mem.data[6] = 8'hff;
        mem.data[7] = 8'hff;
        mem.data[8] = 8'h00;
        mem.data[9] = 8'h80;
        wait_pc(12'h002, t0);
        flags(4'h8);
        wait_pc(12'h004, t1);
        flags(4'he);
        wait_pc(12'h005, t2);
        flags(4'h3);
        wait_pc(12'h006, t3);
        step(4);
        check(16'((t1 - t0) / 4), 16'h0004);
        check(16'((t2 - t1) / 4), 16'h0004);
        check(16'((t3 - t2) / 4), 16'h0002);
        check({mem.data[5], mem.data[6]}, 16'h00ff);
        check({mem.data[7], mem.data[8]}, 16'h0000);
        check(16'(mem.data[9]), 16'h007f);
        check(16'(acc_o), 16'h00ff);
        flags(4'h6);
    endtask : skips

    task automatic calls();
        logic [11:0] seq [6] = '{12'h010, 12'h001, 12'h020, 12'h002, 12'h057, 12'hfff};
        time t, tp;
        restart('{16'h0, op(`OP_CALL, 12'h010), 16'h10, op(`OP_RET_VALUE, 12'h055),
            16'h1, op(`OP_CALL, 12'h020), 16'h20, op(`OP_RET_INT, 12'h000),
            16'h2, op(`OP_PC_ADD, 12'h000), 16'h57, op(`OP_JUMP, 12'hfff), 16'hfff, op(`OP_JUMP, 12'hfff)});
        tp = 0;
        for (int i = 0; i < 6; i++) begin
            wait_pc(seq[i], t);
            if (i > 0) check(16'((t - tp) / 4), 16'h0004);
            tp = t;
        end
        check(16'(acc_o), 16'h0055);
        check(16'(int_enable_o), 16'h0001);
        check(mem.stack[0], 16'h0002);
        check(16'(stack_addr_o), 16'h0000);
        flags(4'h0);
    endtask : calls

    task automatic system_ops();
        time t;
        restart('{16'h0, op(`OP_INT_ON, 12'h000), 16'h1, op(`OP_WDT_CLEAR, 12'h000),
            16'h2, op(`OP_INT_OFF, 12'h000), 16'h3, op(`OP_HALT_SYS, 12'h000),
            16'h4, op(`OP_HALT_CORE, 12'h000), 16'h5, op(`OP_JUMP, 12'h005)});
        wait_pc(12'h004, t);
        check(16'({sys_clock_stop_o, core_clock_stop_o}), 16'h0002);
        step(8);
        check(16'({sys_clock_stop_o, pmem_addr_o}), 16'h1004);
        check(16'(gie_n), 16'h0004);
        check(16'(wdt_n), 16'h0001);
        wake_i = 1'b1;
        step(1);
        wake_i = 1'b0;
        check(16'(sys_clock_stop_o), 16'h0000);
        wait_pc(12'h005, t);
        step(8);
        check(16'({sys_clock_stop_o, core_clock_stop_o, pmem_addr_o}), 16'h1005);
        wake_i = 1'b1;
        step(1);
        wake_i = 1'b0;
        check(16'(core_clock_stop_o), 16'h0000);
    endtask : system_ops

    task automatic soft_reset();
        time t;
        restart('{16'h0, op(`OP_DEC_SKIP_ACC, 12'h000), 16'h1, op(`OP_CALL, 12'h010),
            16'h10, op(`OP_INT_ON, 12'h000), 16'h11, op(`OP_SOFT_RESET, 12'h000)});
        for (int i = 0; i < 60 && soft_reset_o !== 1'b1; i++) step(1);
        check(16'(soft_reset_o), 16'h0001);
        check(16'({acc_o, int_enable_o, pmem_addr_o[6:0]}), 16'h0000);
        flags(4'h0);
        mem.stack[0] = 16'h0000;
        wait_pc(12'h010, t);
        step(1);
        check(mem.stack[0], 16'h0002);
    endtask : soft_reset

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic complete_run();
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    // The limit of 5000 clocks is some fifty times the hundred or so clocks the scenarios need.
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end

    initial begin
        skips();
        calls();
        system_ops();
        soft_reset();
        complete_run();
    end
endmodule : cpu_flow_and_system_control_tb

`default_nettype wire

// ---- tb/mem_model.sv ----
// Purpose: Program, data and stack memories seen by the flow control core.
// Assumes: The core registers its addresses; reads answer combinationally.
// Notes: The bench loads the arrays directly before each run.
`timescale 1ns/10ps
`default_nettype none

module mem_model (
    input wire logic clock_i,
    input wire logic [11:0] pmem_addr_i,
    output logic [15:0] instr_o,
    input wire logic [7:0] dmem_addr_i,
    output logic [7:0] dmem_rdata_o,
    input wire logic [7:0] dmem_wdata_i,
    input wire logic dmem_we_i,
    input wire logic [7:0] stack_addr_i,
    output logic [15:0] stack_rdata_o,
    input wire logic [15:0] stack_wdata_i,
    input wire logic stack_we_i
);
    logic [15:0] prog [4096];
    logic [7:0] data [256];
    logic [15:0] stack [256];

    assign instr_o = prog[pmem_addr_i];
    assign dmem_rdata_o = data[dmem_addr_i];
    assign stack_rdata_o = stack[stack_addr_i];

    // Writes land on the edge that ends the one-clock strobe.
    always @(posedge clock_i) begin
        if (dmem_we_i) data[dmem_addr_i] <= dmem_wdata_i;
        if (stack_we_i) stack[stack_addr_i] <= stack_wdata_i;
    end
endmodule : mem_model

`default_nettype wire
